// *** design/oled_pkg.sv ***
// Purpose: shared constants, types and states for the display reset block
// Assumes: 32-bit APB data, one aligned word per register
// Notes:   display defaults match a 128x64 panel configuration
package oled_pkg;

   // register byte offsets
   localparam int           ADDR_W      = 8;
   localparam logic [7:0]   OFS_CTRL    = 8'h00;
   localparam logic [7:0]   OFS_STATUS  = 8'h04;
   localparam logic [7:0]   OFS_CONFIG  = 8'h08;

   // control, status and config field positions
   localparam int           CTRL_INIT_BIT  = 0;
   localparam int           ST_ON_BIT      = 0;
   localparam int           ST_ENTIRE_BIT  = 1;
   localparam int           ST_INVERSE_BIT = 2;
   localparam int           ST_REMAP_BIT   = 3;
   localparam int           ST_SCAN_BIT    = 4;
   localparam int           ST_BUSY_BIT    = 5;
   localparam int           ST_INIT_BIT    = 6;
   localparam int           CFG_CONTRAST_LSB = 0;
   localparam int           CFG_START_LSB    = 8;
   localparam int           CFG_COL_LSB      = 16;
   localparam int           CFG_MUX_LSB      = 24;

   // serial link target address
   localparam logic [6:0]   TARGET_ADDR = 7'h3c;

   // command codes
   localparam logic [7:0]   CMD_DISP_OFF    = 8'hae;
   localparam logic [7:0]   CMD_DISP_ON     = 8'haf;
   localparam logic [7:0]   CMD_CONTRAST    = 8'h81;
   localparam logic [7:0]   CMD_MUX         = 8'ha8;
   localparam logic [7:0]   CMD_SEG_NORM    = 8'ha0;
   localparam logic [7:0]   CMD_SEG_REMAP   = 8'ha1;
   localparam logic [7:0]   CMD_ENTIRE_NORM = 8'ha4;
   localparam logic [7:0]   CMD_ENTIRE_ON   = 8'ha5;
   localparam logic [7:0]   CMD_INV_OFF     = 8'ha6;
   localparam logic [7:0]   CMD_INV_ON      = 8'ha7;
   localparam logic [7:0]   CMD_SCAN_NORM   = 8'hc0;
   localparam logic [7:0]   CMD_SCAN_REV    = 8'hc8;

   // values after reset
   localparam logic [7:0]   CONTRAST_RESET = 8'h7f;
   localparam logic [5:0]   MUX_RESET      = 6'h3f;
   localparam logic [5:0]   START_RESET    = 6'h00;
   localparam logic [6:0]   COLUMN_RESET   = 7'h00;
   localparam logic [2:0]   SYNC_RESET     = 3'b011; // init low, link idle high

   typedef struct packed {
      logic        display_on;
      logic        entire_on;
      logic        inverse;
      logic        seg_remap;
      logic        scan_reverse;
      logic [5:0]  mux_ratio;
      logic [5:0]  start_line;
      logic [6:0]  column;
      logic [7:0]  contrast;
   } disp_state_type;

   localparam disp_state_type DISP_RESET = '{
      display_on: 1'b0, entire_on: 1'b0, inverse: 1'b0, seg_remap: 1'b0,
      scan_reverse: 1'b0, mux_ratio: MUX_RESET, start_line: START_RESET,
      column: COLUMN_RESET, contrast: CONTRAST_RESET};

   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [31:0]       pwdata;
   } apb_req_type;

   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } apb_rsp_type;

   typedef struct packed {
      logic        valid;
      logic        frame_start;
      logic [7:0]  data;
   } rx_byte_type;

   typedef enum logic [2:0] {
      RX_IDLE = 3'b000,
      RX_ADDR = 3'b001,
      RX_DATA = 3'b010,
      RX_ACK  = 3'b011,
      RX_SKIP = 3'b100
   } rx_state_type;

   typedef enum logic [1:0] {
      PS_CTRL = 2'b00,
      PS_CMD  = 2'b01,
      PS_ARG  = 2'b10,
      PS_DATA = 2'b11
   } parse_state_type;

endpackage

// *** design/pin_sync.sv ***
// Purpose: two-flop synchroniser for a group of pins
// Assumes: pins are asynchronous to pclk
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync #(
   parameter int           W         = 3,
   parameter logic [W-1:0] RESET_VAL = '0
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         ce,
   input  wire logic [W-1:0] pins,
   output logic      [W-1:0] pins_sync
);
   import oled_pkg::*;

   logic [W-1:0] meta_reg;

   // metastability settles in meta_reg before anyone looks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_reg  <= RESET_VAL;
         pins_sync <= RESET_VAL;
      end else if (ce) begin
         meta_reg  <= pins;
         pins_sync <= meta_reg;
      end
   end
endmodule // pin_sync

// *** design/i2c_target_rx.sv ***
// Purpose: write-only two-wire target, assembles bytes and acknowledges
// Assumes: scl and sda already synchronised to pclk
// Notes:   reads from the host are not acknowledged
`timescale 1ns/1ps
module i2c_target_rx (
   input  wire logic          pclk,
   input  wire logic          presetn,
   input  wire logic          ce,
   input  wire logic          clr,
   input  wire logic          scl,
   input  wire logic          sda,
   output oled_pkg::rx_byte_type rx,
   output logic               sda_oe_n,
   output logic               busy
);
   import oled_pkg::*;

   rx_state_type state_reg;
   logic         scl_prev_reg;
   logic         sda_prev_reg;
   logic [2:0]   bit_cnt_reg;
   logic [7:0]   shift_reg;
   logic         full_reg;
   logic         scl_rise;
   logic         scl_fall;
   logic         start_cond;
   logic         stop_cond;

   // line events from the previous sample
   assign scl_rise   = scl & ~scl_prev_reg;
   assign scl_fall   = ~scl & scl_prev_reg;
   assign start_cond = scl & scl_prev_reg & sda_prev_reg & ~sda;
   assign stop_cond  = scl & scl_prev_reg & ~sda_prev_reg & sda;
   assign busy       = (state_reg != RX_IDLE);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else if (ce) begin
         scl_prev_reg <= scl;
         sda_prev_reg <= sda;
      end
   end

   // byte assembly, address match and acknowledge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg   <= RX_IDLE;
         bit_cnt_reg <= 3'h0;
         shift_reg   <= 8'h00;
         full_reg    <= 1'b0;
         sda_oe_n    <= 1'b1;
         rx          <= '0;
      end else if (ce) begin
         rx.valid       <= 1'b0;
         rx.frame_start <= 1'b0;
         if (clr) begin
            state_reg   <= RX_IDLE;
            shift_reg   <= 8'h00;
            bit_cnt_reg <= 3'h0;
            full_reg    <= 1'b0;
            sda_oe_n    <= 1'b1;
         end else if (start_cond) begin
            state_reg   <= RX_ADDR;
            shift_reg   <= 8'h00;
            bit_cnt_reg <= 3'h0;
            full_reg    <= 1'b0;
            sda_oe_n    <= 1'b1;
         end else if (stop_cond) begin
            state_reg <= RX_IDLE;
            full_reg  <= 1'b0;
            sda_oe_n  <= 1'b1;
         end else begin
            unique case (state_reg)
               RX_IDLE, RX_SKIP: begin
                  sda_oe_n <= 1'b1;
               end
               RX_ADDR, RX_DATA: begin
                  if (scl_rise) begin
                     shift_reg   <= {shift_reg[6:0], sda};
                     bit_cnt_reg <= bit_cnt_reg + 3'h1;
                     full_reg    <= (bit_cnt_reg == 3'h7);
                  end else if (scl_fall && full_reg) begin
                     full_reg <= 1'b0;
                     if (state_reg == RX_DATA) begin
                        state_reg <= RX_ACK;
                        sda_oe_n  <= 1'b0;
                        rx.valid  <= 1'b1;
                        rx.data   <= shift_reg;
                     end else if (shift_reg[7:1] == TARGET_ADDR &&
                                  !shift_reg[0]) begin
                        state_reg      <= RX_ACK;
                        sda_oe_n       <= 1'b0;
                        rx.frame_start <= 1'b1;
                     end else begin
                        state_reg <= RX_SKIP;
                     end
                  end
               end
               RX_ACK: begin
                  if (scl_fall) begin
                     sda_oe_n    <= 1'b1;
                     state_reg   <= RX_DATA;
                     bit_cnt_reg <= 3'h0;
                  end
               end
               default: begin
                  state_reg <= RX_IDLE;
                  sda_oe_n  <= 1'b1;
               end
            endcase
         end
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_shift_clear: assert property ((ce && clr) |=>
      (shift_reg == 8'h00 && state_reg == RX_IDLE && sda_oe_n))
      else $error("partial byte survived an init");
   chk_addr_foreign: assert property ((ce && !clr && !start_cond &&
      !stop_cond && state_reg == RX_ADDR && scl_fall && full_reg &&
      shift_reg[7:1] != TARGET_ADDR) |=> (state_reg == RX_SKIP && sda_oe_n))
      else $error("foreign address was acknowledged");
   cov_addr_ack: cover property (rx.frame_start);
endmodule // i2c_target_rx

// *** design/oled_reset_power_sequencing.sv ***
// Purpose: display driver core state with hardware init and command link
// Assumes: pclk 50 MHz; pins asynchronous; host keeps supply sequencing
// Notes:   supply order and panel delays are host duties, not logic here
// Function
// - while init input is low, state initialises and the panel is off
// - init selects the default 128x64 display configuration
// - init restores normal segment and common address mapping from 00h
// - init clears the serial shift register, dropping any partial byte
// - init sets the display start line to memory line 0
// - init loads the column address counter with 0
// - init selects normal scan direction of common outputs
// - init loads contrast with 7Fh
// - init selects normal display output, as after command A4h
// - link commands use target address 0111100b; others are ignored
// - display off is AEh and display on is AFh
//
// Chosen here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module oled_reset_power_sequencing (
   input  wire logic            pclk,
   input  wire logic            presetn,
   input  wire logic            ce,
   input  oled_pkg::apb_req_type apb_req,
   output oled_pkg::apb_rsp_type apb_rsp,
   input  wire logic            hw_init_in_n,
   input  wire logic            scl_in,
   input  wire logic            sda_in,
   output logic                 sda_out,
   output logic                 sda_oe_n,
   output oled_pkg::disp_state_type disp
);
   import oled_pkg::*;

   logic [2:0]      pins_s;
   logic            init_s_n;
   logic            scl_s;
   logic            sda_s;
   logic            soft_init_reg;
   logic            init_now;
   logic            link_busy;
   rx_byte_type     rx;
   parse_state_type ps_reg;
   logic            cont_reg;
   logic            arg_pend_reg;
   logic [7:0]      arg_cmd_reg;
   logic            acc;
   logic            addr_ok;
   logic [31:0]     rdata_mux;

   // every pin crosses two flops before use
   pin_sync #(
      .W         (3),
      .RESET_VAL (SYNC_RESET)
   ) u_sync (
      .pclk      (pclk),
      .presetn   (presetn),
      .ce        (ce),
      .pins      ({hw_init_in_n, scl_in, sda_in}),
      .pins_sync (pins_s)
   );

   assign init_s_n = pins_s[2];
   assign scl_s    = pins_s[1];
   assign sda_s    = pins_s[0];
   // init holds for as long as the pin stays low, not just at its edge
   assign init_now = ~init_s_n | soft_init_reg;

   i2c_target_rx u_rx (
      .pclk     (pclk),
      .presetn  (presetn),
      .ce       (ce),
      .clr      (init_now),
      .scl      (scl_s),
      .sda      (sda_s),
      .rx       (rx),
      .sda_oe_n (sda_oe_n),
      .busy     (link_busy)
   );

   // open-drain data line only ever pulls low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sda_out <= 1'b0;
      end else if (ce) begin
         sda_out <= 1'b0;
      end
   end

   // command stream: control byte, then commands, arguments or pixel data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ps_reg       <= PS_CTRL;
         cont_reg     <= 1'b0;
         arg_pend_reg <= 1'b0;
         arg_cmd_reg  <= 8'h00;
         disp         <= DISP_RESET;
      end else if (ce) begin
         if (init_now) begin
            ps_reg       <= PS_CTRL;
            cont_reg     <= 1'b0;
            arg_pend_reg <= 1'b0;
            disp.display_on   <= 1'b0;
            disp.mux_ratio    <= MUX_RESET;
            disp.seg_remap    <= 1'b0;
            disp.start_line   <= START_RESET;
            disp.column       <= COLUMN_RESET;
            disp.scan_reverse <= 1'b0;
            disp.contrast     <= CONTRAST_RESET;
            disp.entire_on    <= 1'b0;
            disp.inverse      <= 1'b0;
         end else if (rx.frame_start) begin
            ps_reg   <= PS_CTRL;
            cont_reg <= 1'b0;
         end else if (rx.valid) begin
            unique case (ps_reg)
               PS_CTRL: begin
                  // bit 7 clear: all following bytes are of one kind
                  cont_reg <= ~rx.data[7];
                  if (rx.data[6]) begin
                     ps_reg <= PS_DATA;
                  end else if (arg_pend_reg) begin
                     ps_reg <= PS_ARG;
                  end else begin
                     ps_reg <= PS_CMD;
                  end
               end
               PS_CMD: begin
                  if (rx.data == CMD_CONTRAST || rx.data == CMD_MUX) begin
                     arg_pend_reg <= 1'b1;
                     arg_cmd_reg  <= rx.data;
                     ps_reg       <= cont_reg ? PS_ARG : PS_CTRL;
                  end else begin
                     ps_reg <= cont_reg ? PS_CMD : PS_CTRL;
                  end
                  // one-byte settings; unlisted codes change nothing
                  if (rx.data == CMD_DISP_OFF) begin
                     disp.display_on <= 1'b0;
                  end else if (rx.data == CMD_DISP_ON) begin
                     disp.display_on <= 1'b1;
                  end else if (rx.data == CMD_SEG_NORM ||
                               rx.data == CMD_SEG_REMAP) begin
                     disp.seg_remap <= rx.data[0];
                  end else if (rx.data == CMD_ENTIRE_NORM ||
                               rx.data == CMD_ENTIRE_ON) begin
                     disp.entire_on <= rx.data[0];
                  end else if (rx.data == CMD_INV_OFF ||
                               rx.data == CMD_INV_ON) begin
                     disp.inverse <= rx.data[0];
                  end else if (rx.data == CMD_SCAN_NORM ||
                               rx.data == CMD_SCAN_REV) begin
                     disp.scan_reverse <= rx.data[3];
                  end else if (rx.data[7:6] == 2'b01) begin
                     disp.start_line <= rx.data[5:0];
                  end else if (rx.data[7:4] == 4'h0) begin
                     disp.column[3:0] <= rx.data[3:0];
                  end else if (rx.data[7:3] == 5'b00010) begin
                     disp.column[6:4] <= rx.data[2:0];
                  end
               end
               PS_ARG: begin
                  // mux argument keeps only its low six bits
                  arg_pend_reg <= 1'b0;
                  ps_reg       <= cont_reg ? PS_CMD : PS_CTRL;
                  if (arg_cmd_reg == CMD_CONTRAST) begin
                     disp.contrast <= rx.data;
                  end else begin
                     disp.mux_ratio <= rx.data[5:0];
                  end
               end
               PS_DATA: begin
                  // pixel bytes are not stored here, only the column moves
                  disp.column <= disp.column + 7'h01;
                  ps_reg      <= cont_reg ? PS_DATA : PS_CTRL;
               end
            endcase
         end
      end
   end

   // register decode and read data
   assign acc     = apb_req.psel & apb_req.penable;
   assign addr_ok = (apb_req.paddr == OFS_CTRL) ||
                    (apb_req.paddr == OFS_STATUS) ||
                    (apb_req.paddr == OFS_CONFIG);

   // read mux; unmapped offsets read as zero
   always_comb begin
      rdata_mux = 32'h0000_0000;
      if (apb_req.paddr == OFS_STATUS) begin
         rdata_mux[ST_ON_BIT]      = disp.display_on;
         rdata_mux[ST_ENTIRE_BIT]  = disp.entire_on;
         rdata_mux[ST_INVERSE_BIT] = disp.inverse;
         rdata_mux[ST_REMAP_BIT]   = disp.seg_remap;
         rdata_mux[ST_SCAN_BIT]    = disp.scan_reverse;
         rdata_mux[ST_BUSY_BIT]    = link_busy;
         rdata_mux[ST_INIT_BIT]    = ~init_s_n;
      end else if (apb_req.paddr == OFS_CONFIG) begin
         rdata_mux[CFG_CONTRAST_LSB +: 8] = disp.contrast;
         rdata_mux[CFG_START_LSB +: 6]    = disp.start_line;
         rdata_mux[CFG_COL_LSB +: 7]      = disp.column;
         rdata_mux[CFG_MUX_LSB +: 6]      = disp.mux_ratio;
      end
   end

   // one wait state; answer stands for a single access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         apb_rsp <= '0;
      end else if (ce) begin
         if (acc && !apb_rsp.pready) begin
            apb_rsp.pready  <= 1'b1;
            apb_rsp.pslverr <= ~addr_ok;
            apb_rsp.prdata  <= apb_req.pwrite ? 32'h0000_0000 : rdata_mux;
         end else begin
            apb_rsp <= '0;
         end
      end
   end

   // software init pulse, acts like a short hardware init
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         soft_init_reg <= 1'b0;
      end else if (ce) begin
         soft_init_reg <= acc && apb_rsp.pready && apb_req.pwrite &&
                          apb_req.paddr == OFS_CTRL &&
                          apb_req.pwdata[CTRL_INIT_BIT];
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_init_off: assert property ((ce && init_now) |=>
      !disp.display_on)
      else $error("panel not off during init");
   chk_init_mode: assert property ((ce && init_now) |=>
      disp.mux_ratio == 6'h3f)
      else $error("init did not select 128x64 mode");
   chk_init_map: assert property ((ce && init_now) |=> !disp.seg_remap)
      else $error("segment mapping not normal after init");
   chk_init_start: assert property ((ce && init_now) |=>
      disp.start_line == 6'h00)
      else $error("start line not zero after init");
   chk_init_column: assert property ((ce && init_now) |=>
      disp.column == 7'h00)
      else $error("column counter not zero after init");
   chk_init_scan: assert property ((ce && init_now) |=>
      !disp.scan_reverse)
      else $error("scan direction not normal after init");
   chk_init_contrast: assert property ((ce && init_now) |=>
      disp.contrast == 8'h7f)
      else $error("contrast not 7f after init");
   chk_init_normal: assert property ((ce && init_now) |=>
      (!disp.entire_on && !disp.inverse))
      else $error("display output not normal after init");
   chk_disp_on_cmd: assert property ((ce && !init_now &&
      !rx.frame_start && rx.valid && ps_reg == PS_CMD &&
      rx.data == 8'haf) |=> disp.display_on)
      else $error("display on code did not switch panel on");
   chk_disp_off_cmd: assert property ((ce && !init_now &&
      !rx.frame_start && rx.valid && ps_reg == PS_CMD &&
      rx.data == 8'hae) |=> !disp.display_on)
      else $error("display off code did not switch panel off");
   chk_pin_hold: assert property ((ce && !init_s_n)[*3] |->
      ##1 (!disp.display_on && ps_reg == PS_CTRL))
      else $error("state moved while init pin held low");
   chk_apb_answer: assert property ((ce && acc && !apb_rsp.pready) |=>
      (apb_rsp.pready ##1 !apb_rsp.pready))
      else $error("register answer not one cycle long");

   // init side effects, bus answers and parser updates
   chk_init_link: assert property ((ce && init_now) |=>
      (sda_oe_n && !link_busy))
      else $error("link not idle after init");
   chk_init_parser: assert property ((ce && init_now) |=>
      (ps_reg == PS_CTRL && !arg_pend_reg))
      else $error("command parser kept state across init");
   chk_soft_defaults: assert property ((ce && acc && apb_rsp.pready &&
      apb_req.pwrite && apb_req.paddr == OFS_CTRL &&
      apb_req.pwdata[CTRL_INIT_BIT]) |=> ##1 (disp == DISP_RESET))
      else $error("soft init did not restore defaults");
   chk_bad_addr: assert property ((ce && acc && !apb_rsp.pready &&
      !addr_ok) |=> apb_rsp.pslverr)
      else $error("unmapped address not flagged");
   chk_rsp_idle: assert property (!apb_rsp.pready |->
      (apb_rsp.prdata == 32'h0000_0000 && !apb_rsp.pslverr))
      else $error("bus response left standing");
   chk_pixel_column: assert property ((ce && !init_now &&
      !rx.frame_start && rx.valid && ps_reg == PS_DATA) |=>
      disp.column == $past(disp.column) + 7'h01)
      else $error("pixel byte did not advance the column");
   chk_contrast_arg: assert property ((ce && !init_now &&
      !rx.frame_start && rx.valid && ps_reg == PS_ARG &&
      arg_cmd_reg == CMD_CONTRAST) |=> disp.contrast == $past(rx.data))
      else $error("contrast argument not taken");

   cov_disp_on: cover property (!disp.display_on ##1 disp.display_on);
   cov_contrast: cover property (disp.contrast != 8'h7f);
   cov_pixel: cover property (ps_reg == PS_DATA && rx.valid);
   cov_soft_init: cover property (soft_init_reg);
endmodule // oled_reset_power_sequencing

// *** verif/i2c_host_model.sv ***
// Purpose: two-wire host model that sends write frames to the block
// Assumes: bench resolves the open-drain line, pull-up keeps it high
// Notes:   no clock stretching; clock stands high between frames
`timescale 1ns/1ps
module i2c_host_model #(
   parameter int HALF = 16
) (
   input  wire logic pclk,
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_drv
);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   // one bus phase, long enough for the 2-flop sync plus edge detect
   task automatic half_bit();
      repeat (HALF) @(posedge pclk);
   endtask
   // start: data falls while the clock is high
   task automatic start_cond();
      sda_drv <= 1'b0;
      half_bit();
      scl <= 1'b0;
      half_bit();
   endtask
   // stop: data rises while the clock is high
   task automatic stop_cond();
      sda_drv <= 1'b0;
      half_bit();
      scl <= 1'b1;
      half_bit();
      sda_drv <= 1'b1;
      half_bit();
   endtask
   // msb first, then ninth clock sampled for the ack
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_drv <= b[i];
         half_bit();
         scl <= 1'b1;
         half_bit();
         scl <= 1'b0;
      end
      sda_drv <= 1'b1;
      half_bit();
      scl <= 1'b1;
      repeat (HALF / 2) @(posedge pclk);
      ack = !sda_line;
      repeat (HALF / 2) @(posedge pclk);
      scl <= 1'b0;
   endtask
endmodule // i2c_host_model

// *** verif/tb_oled_reset_power_sequencing.sv ***
// Purpose: self-checking bench for the display reset and command block
// Assumes: one clock, apb master and two-wire host in the bench
// Notes:   apb never stalls beyond the one wait state, host waits acks
`timescale 1ns/1ps
module tb_oled_reset_power_sequencing;
   import oled_pkg::*;
   logic           pclk;
   logic           presetn;
   logic           hw_init_in_n;
   logic           ce;
   apb_req_type    apb_req;
   apb_rsp_type    apb_rsp;
   disp_state_type disp;
   logic           scl;
   logic           sda_drv;
   logic           sda_out;
   logic           sda_oe_n;
   logic [31:0]    rd;
   logic           ok;
   int             err_total;
   int             num_checks;
   // pull-up wire: low when either side pulls
   wire sda_line = sda_drv & (sda_oe_n | sda_out);
   oled_reset_power_sequencing dut_u (.pclk(pclk), .presetn(presetn),
      .ce(ce), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .hw_init_in_n(hw_init_in_n), .scl_in(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .disp(disp));
   i2c_host_model host_u (.pclk(pclk), .sda_line(sda_line), .scl(scl),
      .sda_drv(sda_drv));
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // setup, access, wait for pready, release after the sampling edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic err);
      @(posedge pclk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge pclk);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (apb_rsp.pready !== 1'b1);
      rd = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req <= '0;
   endtask
   // whole frame; stops early on a missing ack unless keep is set
   task automatic frame(input logic [7:0] q[$], input logic keep = 1'b0);
      logic a;
      host_u.start_cond();
      ok = 1'b1;
      foreach (q[i]) if (ok || keep) begin
         host_u.send_byte(q[i], a);
         ok = ok & a;
      end
      host_u.stop_cond();
   endtask
   task automatic t_defaults();
      logic e;
      apb(0, OFS_CONFIG, 0, e);
      check(rd, 32'h3f00007f);
      apb(0, OFS_STATUS, 0, e);
      check(rd, 32'h00000000);
      apb(0, 8'h0c, 0, e);
      check(e, 1'b1);
      apb(1, OFS_CONFIG, 32'h12345678, e);
      apb(0, OFS_CONFIG, 0, e);
      check(rd, 32'h3f00007f);
   endtask
   task automatic t_link();
      logic e;
      frame('{8'h78, 8'h80, CMD_DISP_ON});
      check(ok, 1'b1);
      check(disp.display_on, 1'b1);
      frame('{8'h78, 8'h00, CMD_CONTRAST, 8'h33, CMD_SEG_REMAP,
              CMD_SCAN_REV, CMD_INV_ON, CMD_ENTIRE_ON});
      apb(0, OFS_CONFIG, 0, e);
      check(rd, 32'h3f000033);
      apb(0, OFS_STATUS, 0, e);
      check(rd, 32'h0000001f);
   endtask
   task automatic t_hw_init();
      logic e;
      hw_init_in_n <= 1'b0;
      repeat (6) @(posedge pclk);
      check(64'(disp), 64'(DISP_RESET));
      apb(0, OFS_STATUS, 0, e);
      check(rd, 32'h00000040);
      hw_init_in_n <= 1'b1;
      repeat (6) @(posedge pclk);
   endtask
   task automatic t_bad_addr();
      frame('{8'h7a, 8'h80, CMD_DISP_ON}, 1'b1);
      check(ok, 1'b0);
      frame('{8'h79, 8'h80, CMD_DISP_ON}, 1'b1);
      check(ok, 1'b0);
      check(disp.display_on, 1'b0);
   endtask
   task automatic t_soft_init();
      logic e;
      frame('{8'h78, 8'h80, CMD_DISP_ON, 8'h80, CMD_DISP_OFF});
      check(disp.display_on, 1'b0);
      frame('{8'h78, 8'h80, CMD_INV_ON, 8'h80, CMD_DISP_ON});
      // enable low: a low init pin must not reach the state
      ce           <= 1'b0;
      hw_init_in_n <= 1'b0;
      repeat (6) @(posedge pclk);
      check(disp.inverse, 1'b1);
      hw_init_in_n <= 1'b1;
      repeat (3) @(posedge pclk);
      ce           <= 1'b1;
      apb(1, OFS_CTRL, 32'h1, e);
      repeat (3) @(posedge pclk);
      check(64'(disp), 64'(DISP_RESET));
      apb(0, OFS_CTRL, 0, e);
      check(rd, 32'h0);
   endtask
   // power-up: off, init, clear three columns; then on, and off again
   task automatic t_power();
      logic e;
      frame('{8'h78, 8'h00, CMD_DISP_OFF, 8'h40, CMD_SCAN_NORM});
      frame('{8'h78, 8'h40, 8'h00, 8'h00, 8'h00});
      apb(0, OFS_CONFIG, 0, e);
      check(rd, 32'h3f03007f);
      frame('{8'h78, 8'h80, CMD_DISP_ON});
      check(disp.display_on, 1'b1);
      frame('{8'h78, 8'h80, CMD_DISP_OFF});
      check(disp.display_on, 1'b0);
   endtask
   // watchdog: run needs about 13k cycles, limit is 50k
   initial begin
      #1000000;
      err_total++;
      close_out();
   end
   initial begin
      err_total = 0;
      num_checks = 0;
      presetn = 1'b0;
      hw_init_in_n = 1'b1;
      ce = 1'b1;
      apb_req = '0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (6) @(posedge pclk);
      t_defaults();
      t_link();
      t_hw_init();
      t_bad_addr();
      t_soft_init();
      t_power();
      close_out();
   end
endmodule // tb_oled_reset_power_sequencing
